// ===== pwmt_pkg.sv
// Purpose: Shared constants of the PWM timer run control and wave output
// Assumes: APB byte address is four times the register index
// Notes: Control bit positions and reset values live here; the core's control read-back and reset literals repeat them
package pwmt_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam logic [15:0] IDX_CA = 16'h5300;
  localparam logic [15:0] IDX_CB = 16'h5302;
  localparam logic [15:0] IDX_TC = 16'h5304;
  localparam logic [15:0] IDX_CTL = 16'h5306;
  localparam logic [15:0] IDX_IMSK = 16'h530a;
  localparam logic [15:0] IDX_IFLG = 16'h530c;
  localparam logic [17:0] ADDR_CA = {IDX_CA, 2'h0};
  localparam logic [17:0] ADDR_CB = {IDX_CB, 2'h0};
  localparam logic [17:0] ADDR_TC = {IDX_TC, 2'h0};
  localparam logic [17:0] ADDR_CTL = {IDX_CTL, 2'h0};
  localparam logic [17:0] ADDR_IMSK = {IDX_IMSK, 2'h0};
  localparam logic [17:0] ADDR_IFLG = {IDX_IFLG, 2'h0};
  localparam int CTL_RUN = 0;
  localparam int CTL_CLR = 1;
  localparam int CTL_WAVE_EN = 2;
  localparam int CTL_INV = 4;
  localparam int CTL_CBUF = 5;
  localparam int CTL_FINE = 6;
  localparam int CTL_IDLE = 8;
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CTL_WMASK = 16'h0175;
endpackage

// ===== pwmt_edge_sync.sv
// Purpose: Three-stage synchroniser with rise and fall pulses
// Assumes: Input is asynchronous to pclk
// Notes: A change counts once stages two and three agree
`timescale 1ns/1ps
module pwmt_edge_sync
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic rise,
  output logic fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;

  // Stage one feeds stage two only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lvl_reg <= 1'b0;
    else if (s2_reg == s3_reg)
      lvl_reg <= s3_reg;
  end

  assign rise = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
  assign fall = (s2_reg == s3_reg) && !s3_reg && lvl_reg;
endmodule

// ===== pwmt_core.sv
// Purpose: 16-bit up-counting PWM timer with compare A/B wave output
// Assumes: Count clock arrives as a pin well below pclk/4
// Notes: APB slave with one wait state; registers at index times four
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// - Run bit starts; stop keeps counter value
// - Clear plus run: clear first, then count
// - Compare A match raises cause, counting continues
// - Compare B match: cause, restart, load buffers
// - Enabled match causes interrupt request
// - Idle level select: 0 low, 1 high
// - Clear trigger forces output to idle
// - Invert flips waveform and idle level
// - Idle held until first compare A or B match
// - Output enable starts; disable returns idle
// - Low until past A, high; B clears low
// - Default mode transitions on rising count edge
// - Fine mode: A[15:1] vs counter[14:0]
// - Fine mode A zero behaves like default
// - Fine mode select, cleared at reset
// - Default mode A beyond B: only B matches, output low
// - Clear zeroes counter; counter directly writable
// - Buffer select routes compare writes to shadows
module pwmt_core
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwmt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_clk_in,
  output logic timer_wave_out,
  output logic irq_req
);
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [15:0] counter_value_reg;
  logic [15:0] compare_a_value_reg;
  logic [15:0] compare_b_value_reg;
  logic [15:0] buf_a_reg;
  logic [15:0] buf_b_reg;
  logic counter_run_control_reg;
  logic wave_output_enable_reg;
  logic output_polarity_invert_reg;
  logic compare_buffer_select_reg;
  logic half_step_mode_select_reg;
  logic idle_level_select_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_flag_reg;
  logic irq_reg;
  logic wave_reg;
  logic fall_pend_reg;
  logic hold_idle_reg;
  logic wave_pin_reg;
  logic cnt_rise;
  logic cnt_fall;
  logic wr;
  logic rd;
  logic ctl_wr;
  logic clr_wr;
  logic tc_wr;
  logic tick;
  logic match_a;
  logic match_b;
  logic idle_lvl;
  logic wave_lvl;
  logic [1:0] cause;

  function automatic logic hit(input logic [17:0] a, input logic [17:0] r);
    hit = (a == r);
  endfunction

  function automatic logic mapped(input logic [17:0] a);
    mapped = hit(a, pwmt_pkg::ADDR_CA) || hit(a, pwmt_pkg::ADDR_CB) ||
      hit(a, pwmt_pkg::ADDR_TC) || hit(a, pwmt_pkg::ADDR_CTL) ||
      hit(a, pwmt_pkg::ADDR_IMSK) || hit(a, pwmt_pkg::ADDR_IFLG);
  endfunction

  pwmt_edge_sync u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(count_clk_in),
    .rise(cnt_rise),
    .fall(cnt_fall)
  );

  // Writes land at the edge where pready is high; reads are captured one edge earlier, while pready is low
  assign wr = psel && penable && pready_reg && pwrite;
  assign rd = psel && penable && !pready_reg && !pwrite;
  assign ctl_wr = wr && hit(paddr, pwmt_pkg::ADDR_CTL);
  assign clr_wr = ctl_wr && pwdata[pwmt_pkg::CTL_CLR];
  assign tc_wr = wr && hit(paddr, pwmt_pkg::ADDR_TC);
  assign tick = cnt_rise && counter_run_control_reg;
  assign match_b = counter_value_reg == compare_b_value_reg;
  // Fine mode compares the upper fifteen bits of A to the low counter bits
  assign match_a = half_step_mode_select_reg ?
    (compare_a_value_reg[15:1] == counter_value_reg[14:0]) :
    (compare_a_value_reg == counter_value_reg);
  assign idle_lvl = idle_level_select_reg ^ output_polarity_invert_reg;
  assign wave_lvl = wave_reg ^ output_polarity_invert_reg;
  assign cause = {tick && match_b, tick && match_a};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !mapped(paddr);
      if (rd)
      begin
        prdata_reg <= 32'h0000_0000;
        if (hit(paddr, pwmt_pkg::ADDR_CA))
          prdata_reg[15:0] <= compare_buffer_select_reg ?
            buf_a_reg : compare_a_value_reg;
        if (hit(paddr, pwmt_pkg::ADDR_CB))
          prdata_reg[15:0] <= compare_buffer_select_reg ?
            buf_b_reg : compare_b_value_reg;
        if (hit(paddr, pwmt_pkg::ADDR_TC))
          prdata_reg[15:0] <= counter_value_reg;
        if (hit(paddr, pwmt_pkg::ADDR_CTL))
          prdata_reg[15:0] <= {7'h00, idle_level_select_reg, 1'b0,
            half_step_mode_select_reg, compare_buffer_select_reg,
            output_polarity_invert_reg, 1'b0, wave_output_enable_reg,
            1'b0, counter_run_control_reg};
        if (hit(paddr, pwmt_pkg::ADDR_IMSK))
          prdata_reg[1:0] <= irq_mask_reg;
        if (hit(paddr, pwmt_pkg::ADDR_IFLG))
          prdata_reg[1:0] <= irq_flag_reg;
      end
    end
  end

  // Control register; the clear bit is a trigger and reads as zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      counter_run_control_reg <= 1'b0;
      wave_output_enable_reg <= 1'b0;
      output_polarity_invert_reg <= 1'b0;
      compare_buffer_select_reg <= 1'b0;
      half_step_mode_select_reg <= 1'b0;
      idle_level_select_reg <= 1'b0;
    end
    else if (ctl_wr)
    begin
      counter_run_control_reg <= pwdata[pwmt_pkg::CTL_RUN];
      wave_output_enable_reg <= pwdata[pwmt_pkg::CTL_WAVE_EN];
      output_polarity_invert_reg <= pwdata[pwmt_pkg::CTL_INV];
      compare_buffer_select_reg <= pwdata[pwmt_pkg::CTL_CBUF];
      half_step_mode_select_reg <= pwdata[pwmt_pkg::CTL_FINE];
      idle_level_select_reg <= pwdata[pwmt_pkg::CTL_IDLE];
    end
  end

  // Bus writes to the counter win over a count edge in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      counter_value_reg <= pwmt_pkg::CNT_RESET;
    else if (clr_wr)
      counter_value_reg <= pwmt_pkg::CNT_RESET;
    else if (tc_wr)
      counter_value_reg <= pwdata[15:0];
    else if (tick && match_b)
      counter_value_reg <= pwmt_pkg::CNT_RESET;
    else if (tick)
      counter_value_reg <= counter_value_reg + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_a_value_reg <= pwmt_pkg::CMP_RESET;
      compare_b_value_reg <= pwmt_pkg::CMP_RESET;
      buf_a_reg <= pwmt_pkg::CMP_RESET;
      buf_b_reg <= pwmt_pkg::CMP_RESET;
    end
    else
    begin
      if (wr && hit(paddr, pwmt_pkg::ADDR_CA))
      begin
        if (compare_buffer_select_reg)
          buf_a_reg <= pwdata[15:0];
        else
          compare_a_value_reg <= pwdata[15:0];
      end
      if (wr && hit(paddr, pwmt_pkg::ADDR_CB))
      begin
        if (compare_buffer_select_reg)
          buf_b_reg <= pwdata[15:0];
        else
          compare_b_value_reg <= pwdata[15:0];
      end
      // Shadow load on hardware or software counter reset
      if (compare_buffer_select_reg && ((tick && match_b) || clr_wr))
      begin
        compare_a_value_reg <= buf_a_reg;
        compare_b_value_reg <= buf_b_reg;
      end
    end
  end

  // Flags set only while enabled; set beats a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask_reg <= 2'h0;
      irq_flag_reg <= 2'h0;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (wr && hit(paddr, pwmt_pkg::ADDR_IMSK))
        irq_mask_reg <= pwdata[1:0];
      if (wr && hit(paddr, pwmt_pkg::ADDR_IFLG))
        irq_flag_reg <= (irq_flag_reg & ~pwdata[1:0]) |
          (cause & irq_mask_reg);
      else
        irq_flag_reg <= irq_flag_reg | (cause & irq_mask_reg);
      irq_reg <= |(irq_flag_reg & irq_mask_reg);
    end
  end

  // Raw wave: B match wins over A, so in default mode A beyond B never goes high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wave_reg <= 1'b0;
      fall_pend_reg <= 1'b0;
      hold_idle_reg <= 1'b1;
    end
    else if (clr_wr || !wave_output_enable_reg)
    begin
      wave_reg <= 1'b0;
      fall_pend_reg <= 1'b0;
      hold_idle_reg <= 1'b1;
    end
    else if (tick && match_b)
    begin
      wave_reg <= 1'b0;
      fall_pend_reg <= 1'b0;
      hold_idle_reg <= 1'b0;
    end
    else if (tick && match_a &&
      half_step_mode_select_reg && compare_a_value_reg[0])
      fall_pend_reg <= 1'b1;
    else if (tick && match_a)
    begin
      wave_reg <= 1'b1;
      hold_idle_reg <= 1'b0;
    end
    else if (cnt_fall && fall_pend_reg)
    begin
      // Half-step edge is taken on the count clock's falling edge
      wave_reg <= 1'b1;
      fall_pend_reg <= 1'b0;
      hold_idle_reg <= 1'b0;
    end
  end

  // Single output flop keeps the pin free of combining glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wave_pin_reg <= 1'b0;
    else if (wave_output_enable_reg && !hold_idle_reg)
      wave_pin_reg <= wave_lvl;
    else
      wave_pin_reg <= idle_lvl;
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timer_wave_out = wave_pin_reg;
  assign irq_req = irq_reg;

  AST_RUN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !counter_run_control_reg && !ctl_wr && !tc_wr
    |=> $stable(counter_value_reg))
    else $error("Counter moved while stopped");
  AST_CLR_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    clr_wr && pwdata[pwmt_pkg::CTL_RUN]
    |=> counter_value_reg == 16'h0000 && counter_run_control_reg)
    else $error("Clear with run did not clear and run");
  AST_A_CONT: assert property (@(posedge pclk) disable iff (!presetn)
    tick && match_a && !match_b && !ctl_wr && !tc_wr
    |=> counter_value_reg == $past(counter_value_reg) + 16'h0001)
    else $error("Compare A match disturbed counting");
  AST_B_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    tick && match_b && !tc_wr |=> counter_value_reg == 16'h0000)
    else $error("Compare B match did not restart counter");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    cause[pwmt_pkg::IRQ_B] && irq_mask_reg[pwmt_pkg::IRQ_B]
    |=> ##1 irq_req)
    else $error("Enabled match gave no interrupt request");
  AST_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !wave_output_enable_reg |=> timer_wave_out == $past(idle_lvl))
    else $error("Disabled output not at idle level");
  AST_CLR_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    clr_wr |=> ##1 timer_wave_out == $past(idle_lvl))
    else $error("Clear trigger did not force idle level");
  AST_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    fall_pend_reg && cnt_fall && wave_output_enable_reg && !clr_wr &&
    !tick |=> wave_reg)
    else $error("Half-step edge missed");
  AST_A_GT_B: assert property (@(posedge pclk) disable iff (!presetn)
    !half_step_mode_select_reg && wave_output_enable_reg &&
    compare_a_value_reg > compare_b_value_reg &&
    counter_value_reg <= compare_b_value_reg && !wave_reg
    && !ctl_wr && !tc_wr |=> !wave_reg)
    else $error("Wave rose although A beyond B");

  COV_B_MATCH: cover property (@(posedge pclk) disable iff (!presetn)
    tick && match_b);
  COV_FINE: cover property (@(posedge pclk) disable iff (!presetn)
    fall_pend_reg && cnt_fall);
  COV_WAVE: cover property (@(posedge pclk) disable iff (!presetn)
    !timer_wave_out ##1 timer_wave_out);
endmodule

// ===== pwmt_wave_sink.sv
// Purpose: Far-side model: makes the count clock and watches the wave
// Assumes: HALF pclk cycles per count clock phase, HALF >= 8
// Notes: Clock toggles once per step; rises counts rising wave edges
`timescale 1ns/1ps
module pwmt_wave_sink
#(
  parameter int HALF = 10
)
(
  input wire logic pclk,
  input wire logic wave,
  output logic cclk,
  output int rises
);
  initial
  begin
    cclk = 1'b0;
    rises = 0;
  end
  // Counting every rise exposes glitches between the bench's samples
  always @(posedge wave)
    rises++;
  // One phase; long enough for the three-stage sync plus the wave register
  task automatic step();
    @(posedge pclk);
    cclk <= ~cclk;
    repeat (HALF - 1) @(posedge pclk);
  endtask
endmodule

// ===== pwm_timer_run_and_wave_output_tb_top.sv
// Purpose: Self-checking bench for the PWM timer run and wave output
// Assumes: One wait state APB slave; count clock from the sink model
// Notes: Wave and counter are predicted from integer half-step positions
`timescale 1ns/1ps
module pwm_timer_run_and_wave_output_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [pwmt_pkg::ADDR_W-1:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, count_clk_in, timer_wave_out, irq_req;
  int rises;
  int failures = 0;
  int checks = 0;
  int seed = 32'h1fda8643;
  logic [17:0] regs [6] = '{pwmt_pkg::ADDR_CA, pwmt_pkg::ADDR_CB,
    pwmt_pkg::ADDR_TC, pwmt_pkg::ADDR_CTL, pwmt_pkg::ADDR_IMSK,
    pwmt_pkg::ADDR_IFLG};

  always #4 pclk = ~pclk;

  pwmt_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_clk_in(count_clk_in), .timer_wave_out(timer_wave_out),
    .irq_req(irq_req));
  pwmt_wave_sink #(.HALF(10)) i_sink (.pclk(pclk), .wave(timer_wave_out),
    .cclk(count_clk_in), .rises(rises));

  task automatic summarize();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Entered right after a rising edge; leaves one idle edge behind it
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [17:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] d;
    logic e;
    logic [15:0] ctl;
    int a, b, c, ph, w, hi, mr, r0, fine, inv, idle;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("wave_rst", 32'h0, {31'h0, timer_wave_out});
    for (int i = 0; i < 6; i++)
    begin
      rd(regs[i], r);
      chk("reset_val", 32'h0, r);
    end
    apb(1'b0, 18'h3fffc, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    d = $random(seed);
    wr(pwmt_pkg::ADDR_CTL, d);
    rd(pwmt_pkg::ADDR_CTL, r);
    chk("ctl_rb", {16'h0, d[15:0] & pwmt_pkg::CTL_WMASK}, r);
    wr(pwmt_pkg::ADDR_CTL, 32'h0);
    d = $random(seed);
    wr(pwmt_pkg::ADDR_TC, d);
    rd(pwmt_pkg::ADDR_TC, r);
    chk("tc_rb", {16'h0, d[15:0]}, r);
    wr(pwmt_pkg::ADDR_IMSK, 32'h3);
    for (int m = 0; m < 8; m++)
    begin
      inv = m & 1;
      fine = (m >> 1) & 1;
      idle = (m >> 2) & 1;
      b = 2 + ($unsigned($random(seed)) % 6);
      // Fine mode keeps A below twice B; default may pass B on purpose
      a = $unsigned($random(seed)) % (fine ? 2 * b : b + 2);
      if (!fine && a == b)
        a = b + 1;
      // Buffer select follows fine so both compare write routes get used
      ctl = 16'((idle << 8) | (fine << 6) | (fine << 5) | (inv << 4));
      // Setup order: output options, counter, then compare values
      wr(pwmt_pkg::ADDR_CTL, {16'h0, ctl});
      wr(pwmt_pkg::ADDR_TC, $random(seed));
      wr(pwmt_pkg::ADDR_CA, 32'(a));
      wr(pwmt_pkg::ADDR_CB, 32'(b));
      rd(pwmt_pkg::ADDR_CA, r);
      chk("ca_rb", 32'(a), r);
      chk("idle_lvl", 32'(idle ^ inv), {31'h0, timer_wave_out});
      wr(pwmt_pkg::ADDR_CTL, {16'h0, (ctl & 16'hfeff) | 16'h0007});
      repeat (3) @(posedge pclk);
      chk("enable_lvl", 32'(inv), {31'h0, timer_wave_out});
      c = 0;
      ph = 0;
      mr = 0;
      hi = inv;
      r0 = rises;
      for (int k = 0; k < 4 * b + 6; k++)
      begin
        i_sink.step();
        ph = 1 - ph;
        if (ph == 1)
          c = (c == b) ? 0 : c + 1;
        w = (fine ? (2 * c + 1 - ph >= a + 2) : (c > a)) ^ inv;
        if (w == 1 && hi == 0)
          mr++;
        hi = w;
        chk("wave", 32'(w), {31'h0, timer_wave_out});
      end
      chk("rises", 32'(mr), 32'(rises - r0));
      wr(pwmt_pkg::ADDR_CTL, {16'h0, ctl});
      rd(pwmt_pkg::ADDR_TC, r);
      chk("wave_off", 32'(idle ^ inv), {31'h0, timer_wave_out});
      chk("tc_hold", 32'(c), r);
      repeat (4) i_sink.step();
      rd(pwmt_pkg::ADDR_TC, r);
      chk("tc_stop", 32'(c), r);
      chk("irq", 32'h1, {31'h0, irq_req});
      rd(pwmt_pkg::ADDR_IFLG, r);
      chk("flags", 32'(2 + (fine | (a < b))), r);
      wr(pwmt_pkg::ADDR_IFLG, 32'h3);
      rd(pwmt_pkg::ADDR_IFLG, r);
      chk("flag_clr", 32'h0, r);
      chk("irq_clr", 32'h0, {31'h0, irq_req});
    end
    summarize();
  end
endmodule
